// ---- rtl/cfg_params.svh ----
// constants for the converter configuration register and its serial link
`ifndef CFG_PARAMS_SVH
`define CFG_PARAMS_SVH

`define CR_WIDTH 32
`define CR_RESET_VALUE 32'h000003FF
`define CR_UNUSED_MASK 32'h00081000
`define CR_HW_KEEP_MASK 32'h0077E3FF
`define CR_UPPER_LSB 24
`define CR_READ_EN_BIT 17
`define CR_FULL_UPD_BIT 16
`define FRAME_BITS 32
`define BIT_CNT_W 6
`define PIN_SYNC_W 24
`define DB_WIDTH 16
`define CHAIN_PIN_A 5
`define CHAIN_PIN_B 4
`define CHAIN_PIN_C 3
`define CHAIN_FIFO_DEPTH 16
`define CHAIN_FIFO_WIDTH 3
`define SCLK_PERIOD_NS 320
`define SYS_PERIOD_NS 40

`endif

// ---- rtl/cfg_pkg.sv ----
// types for the converter configuration register block
package cfg_pkg;
  typedef struct packed {
    logic pair_c_enable;
    logic pair_b_enable;
    logic pair_a_enable;
    logic range_c_double;
    logic range_b_double;
    logic range_a_double;
    logic internal_ref_on;
    logic ref_buffer_off;
    logic interleaved_start;
    logic auto_sleep;
    logic status_is_irq;
    logic status_invert;
    logic unused_19;
    logic ref_is_3v;
    logic read_enable;
    logic full_update_enable;
    logic pair_c_sleep;
    logic pair_b_sleep;
    logic pair_a_sleep;
    logic unused_12;
    logic conv_clock_source;
    logic conv_clock_export;
    logic [9:0] reference_level_code;
  } converter_configuration_t;

  typedef struct packed {
    logic sclk;
    logic frame_sync_n;
    logic serial_config_in;
    logic chip_select_n;
    logic write_strobe_n;
    logic chain_enable;
    logic config_source_select;
    logic port_type_select;
    logic [15:0] data_bus;
  } pins_t;

  typedef struct packed {
    logic [31:0] port_c;
    logic [31:0] port_b;
    logic [31:0] port_a;
  } conv_words_t;
endpackage : cfg_pkg

// ---- rtl/chain_fifo.sv ----
// small synchronous fifo for daisy-chain bits
`timescale 1ns/1ns
`default_nettype none
module chain_fifo #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  wire full = (count_r == (PW+1)'(DEPTH));
  wire empty = (count_r == '0);
  wire push = in_valid_i & ~full;
  wire pop = out_ready_i & ~empty;

  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = mem_r[rd_ptr_r];

  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : chain_fifo
`default_nettype wire

// ---- rtl/adc_control_register_chain.sv ----
// configuration register, serial/parallel access and daisy chain
`timescale 1ns/1ns
`default_nettype none
`include "cfg_params.svh"

// Function
// - top bits enable pairs c, b, a
// - range bits pick four or two times reference
// - one switches internal reference on
// - one turns reference buffers off
// - auto sleep bit, also in hardware mode
// - status pin shows busy or interrupt
// - polarity bit inverts status pin sense
// - reference voltage 2.5V or 3V
// - read enable shifts register out next access
// - serial full-update bit widens write scope
// - clock source internal or external
// - export internal clock on shared pin
// - ten-bit reference code resets to ones
// - hardware mode ignores top bits and clock bits
// - chain only serial and enable pin high
// - data pins 5,4,3 feed chain inputs
// - write lands at strobe rise or 32nd fall
// - writable only in software mode, retained
// - latch on fall, shift out msb on rise
module adc_control_register_chain (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire cfg_pkg::pins_t pins_i,
  input wire cfg_pkg::conv_words_t conv_words_i,
  input wire logic conv_busy_i,
  input wire logic conv_irq_i,
  input wire logic int_conv_clk_i,
  output cfg_pkg::converter_configuration_t eff_cfg_o,
  output logic [31:0] converter_configuration_o,
  output logic [2:0] serial_out_port_o,
  output logic status_pin_o,
  output logic shared_clk_o,
  output logic shared_clk_oe_n_o
);
  import cfg_pkg::*;

  // masks bits that hardware mode ignores
  function automatic logic [31:0] hw_view(input logic [31:0] cr,
                                         input logic sw_mode);
    hw_view = sw_mode ? cr : (cr & `CR_HW_KEEP_MASK);
  endfunction : hw_view

  // unused bits are stored as zero whatever the host sends
  function automatic logic [31:0] clean(input logic [31:0] v);
    clean = v & ~`CR_UNUSED_MASK;
  endfunction : clean

  // pin synchroniser, second stage is the only reader of the first
  pins_t sync1_r;
  pins_t sync2_r;
  pins_t prev_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_r <= '1;
      sync2_r <= '1;
      prev_r <= '1;
    end else begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  wire sw_mode = sync2_r.config_source_select;
  wire serial_mode = sync2_r.port_type_select;
  wire sclk_rise = sync2_r.sclk & ~prev_r.sclk;
  wire sclk_fall = ~sync2_r.sclk & prev_r.sclk;
  wire fs_fall = ~sync2_r.frame_sync_n & prev_r.frame_sync_n;
  wire in_frame = ~sync2_r.frame_sync_n;
  wire wr_rise = sync2_r.write_strobe_n & ~prev_r.write_strobe_n;
  wire chain_on = serial_mode & sync2_r.chain_enable;

  // configuration register
  logic [31:0] cr_r;
  logic [31:0] cr_nxt;
  logic [7:0] par_hold_r;
  logic par_second_r;

  // serial input side
  logic [31:0] in_sreg_r;
  logic [`BIT_CNT_W-1:0] in_cnt_r;
  logic [31:0] in_word;
  wire ser_last_fall = in_frame & sclk_fall &
                       (in_cnt_r == `BIT_CNT_W'(`FRAME_BITS - 1));
  assign in_word = {in_sreg_r[30:0], sync2_r.serial_config_in};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      in_sreg_r <= '0;
      in_cnt_r <= '0;
    end else if (fs_fall) begin
      in_cnt_r <= '0;
    end else if (in_frame & sclk_fall) begin
      in_sreg_r <= in_word;
      if (in_cnt_r != `BIT_CNT_W'(`FRAME_BITS)) in_cnt_r <= in_cnt_r + 1'b1;
    end
  end

  wire par_write = ~serial_mode & sw_mode & wr_rise &
                   ~sync2_r.chip_select_n;
  wire ser_write = serial_mode & sw_mode & ser_last_fall;

  always_comb begin
    cr_nxt = cr_r;
    if (ser_write) begin
      if (in_word[`CR_FULL_UPD_BIT]) begin
        cr_nxt = clean(in_word);
      end else begin
        cr_nxt[31:`CR_UPPER_LSB] = in_word[31:`CR_UPPER_LSB];
      end
    end else if (par_write) begin
      if (!par_second_r) begin
        cr_nxt[31:`CR_UPPER_LSB] = sync2_r.data_bus[15:8];
      end else begin
        cr_nxt[23:0] = 24'(clean({8'h00, par_hold_r, sync2_r.data_bus}));
      end
    end
  end

  // commit at strobe rise or 32nd fall
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cr_r <= `CR_RESET_VALUE;
    end else begin
      cr_r <= cr_nxt;
    end
  end

  // two word writes while chip select stays low; a lone first word
  // still lands the upper byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      par_hold_r <= '0;
      par_second_r <= 1'b0;
    end else if (sync2_r.chip_select_n) begin
      par_second_r <= 1'b0;
    end else if (par_write) begin
      par_hold_r <= sync2_r.data_bus[7:0];
      par_second_r <= ~par_second_r;
    end
  end

  converter_configuration_t eff_nxt;
  assign eff_nxt = converter_configuration_t'(hw_view(cr_r, sw_mode));

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      eff_cfg_o <= converter_configuration_t'(`CR_RESET_VALUE);
    end else begin
      // clock source, all passed through the view
      eff_cfg_o <= eff_nxt;
    end
  end

  assign converter_configuration_o = cr_r;

  wire status_nxt = eff_nxt.status_is_irq ?
                    (conv_irq_i ~^ eff_nxt.status_invert) :
                    (conv_busy_i ^ eff_nxt.status_invert);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      status_pin_o <= 1'b0;
    end else begin
      status_pin_o <= status_nxt;
    end
  end

  // external source means the pin is an input
  wire export_clk = eff_nxt.conv_clock_export &
                    ~eff_nxt.conv_clock_source;
  assign shared_clk_o = int_conv_clk_i;
  assign shared_clk_oe_n_o = ~export_clk;

  wire [2:0] chain_bits = {sync2_r.data_bus[`CHAIN_PIN_C],
                           sync2_r.data_bus[`CHAIN_PIN_B],
                           sync2_r.data_bus[`CHAIN_PIN_A]};

  // chain fifo: filled on falling edges, drained on rising edges once
  // the own words are out; a full fifo refuses and the bit is lost,
  // so upstream bits 17 to 32 of a frame are lost until the 33rd rise pops
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [2:0] fifo_out_data;
  logic own_done_r;
  logic [`BIT_CNT_W-1:0] out_cnt_r;
  // own word ends once 32 rises have passed; the 33rd rise pops
  wire own_last = (out_cnt_r == `BIT_CNT_W'(`FRAME_BITS));
  wire fifo_push = chain_on & in_frame & sclk_fall & fifo_in_ready;
  wire fifo_pop = chain_on & in_frame & sclk_rise &
                  (own_done_r | own_last);
  // fifo is flushed at each frame start
  logic fifo_rst;
  assign fifo_rst = rst_i | fs_fall;

  chain_fifo #(
    .WIDTH(`CHAIN_FIFO_WIDTH),
    .DEPTH(`CHAIN_FIFO_DEPTH)
  ) u_chain_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_i(fifo_rst),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(chain_bits),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out_data)
  );

  // serial output side
  logic [31:0] out_a_r;
  logic [31:0] out_b_r;
  logic [31:0] out_c_r;
  logic [2:0] chain_out_r;
  logic chain_frame_r;

  // readback replaces results on every access while the read enable bit stays set
  wire readback = cr_r[`CR_READ_EN_BIT];

  // load msb at frame start, shift on rising edge
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      out_a_r <= '0;
      out_b_r <= '0;
      out_c_r <= '0;
      out_cnt_r <= '0;
      own_done_r <= 1'b0;
    end else if (fs_fall) begin
      out_a_r <= readback ? cr_r : conv_words_i.port_a;
      out_b_r <= readback ? cr_r : conv_words_i.port_b;
      out_c_r <= readback ? cr_r : conv_words_i.port_c;
      out_cnt_r <= '0;
      own_done_r <= 1'b0;
    end else if (in_frame & sclk_rise & ~own_done_r) begin
      // msb already stands from frame start, so the first rise keeps it
      if (out_cnt_r != '0) begin
        out_a_r <= {out_a_r[30:0], 1'b0};
        out_b_r <= {out_b_r[30:0], 1'b0};
        out_c_r <= {out_c_r[30:0], 1'b0};
      end
      if (own_last) begin
        own_done_r <= 1'b1;
      end else begin
        out_cnt_r <= out_cnt_r + 1'b1;
      end
    end
  end

  // chain gate held per frame, so a pin change between frames
  // cannot move the serial outputs without a clock rise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      chain_frame_r <= 1'b0;
    end else if (fs_fall) begin
      chain_frame_r <= chain_on;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i | fs_fall) begin
      chain_out_r <= '0;
    end else if (fifo_pop) begin
      chain_out_r <= fifo_out_valid ? fifo_out_data : 3'h0;
    end
  end

  wire [2:0] ser_nxt = own_done_r ?
                       (chain_frame_r ? chain_out_r : 3'h0) :
                       {out_c_r[31], out_b_r[31], out_a_r[31]};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      serial_out_port_o <= '0;
    end else begin
      serial_out_port_o <= ser_nxt;
    end
  end
endmodule : adc_control_register_chain
`default_nettype wire

// ---- sim/cfg_sva.sv ----
// concurrent checks on the configuration register block
`timescale 1ns/1ns
`default_nettype none
module cfg_sva (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire cfg_pkg::pins_t pins_i,
  input wire logic conv_busy_i,
  input wire logic conv_irq_i,
  input wire logic int_conv_clk_i,
  input wire cfg_pkg::converter_configuration_t eff_cfg_o,
  input wire logic [31:0] converter_configuration_o,
  input wire logic [2:0] serial_out_port_o,
  input wire logic status_pin_o,
  input wire logic shared_clk_o,
  input wire logic shared_clk_oe_n_o
);
  import cfg_pkg::*;
  logic [5:0] rise_h;
  logic [5:0] fall_h;
  wire logic sw = pins_i.config_source_select;
  // pin history, since pins reach the logic a few edges late
  always_ff @(posedge clk_sys_i) begin
    rise_h <= {rise_h[4:0], pins_i.sclk};
    fall_h <= {fall_h[4:0], pins_i.frame_sync_n};
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  chk_reset_value:
    assert property (disable iff (1'b0)
      rst_i |=> converter_configuration_o == 32'h000003FF)
    else $error("bad reset value");
  chk_hw_mask:
    assert property (!sw [*6] |-> (eff_cfg_o & 32'hFF881C00) == 32'h0)
    else $error("hardware mode bits not masked");
  chk_sw_view:
    assert property (sw [*6] |-> eff_cfg_o == $past(converter_configuration_o))
    else $error("effective view lags wrongly");
  chk_hw_hold:
    assert property (!sw [*6] |=> $stable(converter_configuration_o))
    else $error("register written in hardware mode");
  chk_oe_view:
    assert property (1'b1 |=> $past(shared_clk_oe_n_o) ==
      !(eff_cfg_o.conv_clock_export && !eff_cfg_o.conv_clock_source))
    else $error("clock export enable wrong");
  chk_clk_copy:
    assert property (shared_clk_o == int_conv_clk_i)
    else $error("shared clock not forwarded");
  chk_status_sense:
    assert property (!$past(rst_i) && $stable(eff_cfg_o) |->
      status_pin_o == (eff_cfg_o.status_is_irq ?
      ($past(conv_irq_i) ~^ eff_cfg_o.status_invert) :
      ($past(conv_busy_i) ^ eff_cfg_o.status_invert)))
    else $error("status pin sense wrong");
  chk_out_timing:
    assert property (!$past(rst_i) && $changed(serial_out_port_o) |->
      (|(rise_h[4:2] & ~rise_h[5:3])) || (|(~fall_h[4:2] & fall_h[5:3])))
    else $error("serial out moved off a clock rise");
  cover property ($changed(converter_configuration_o));
  cover property (!shared_clk_oe_n_o);
  cover property (eff_cfg_o.status_is_irq && status_pin_o);
endmodule : cfg_sva
bind adc_control_register_chain cfg_sva cfg_sva_inst (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .pins_i(pins_i),
  .conv_busy_i(conv_busy_i), .conv_irq_i(conv_irq_i),
  .int_conv_clk_i(int_conv_clk_i), .eff_cfg_o(eff_cfg_o),
  .converter_configuration_o(converter_configuration_o),
  .serial_out_port_o(serial_out_port_o), .status_pin_o(status_pin_o),
  .shared_clk_o(shared_clk_o), .shared_clk_oe_n_o(shared_clk_oe_n_o));
`default_nettype wire

// ---- sim/host_model.sv ----
// host link model: serial frames plus an upstream chain device
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk_sys_i,
  input wire logic [2:0] sout_i,
  output logic sclk_o,
  output logic sync_n_o,
  output logic din_o,
  output logic [2:0] chain_o
);
  initial begin
    sclk_o = 1'b0;
    sync_n_o = 1'b1;
    din_o = 1'b0;
    chain_o = 3'b110;
  end
  task automatic frame(input logic [31:0] w, input int nb,
      output logic [31:0] ra, output logic [31:0] rb,
      output logic [31:0] rc, output logic [2:0] tail);
    sync_n_o <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    for (int i = 0; i < nb; i++) begin
      sclk_o <= 1'b1;
      din_o <= (i < 32) ? w[31-i] : ~din_o;
      repeat (4) @(posedge clk_sys_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      // read late in the low phase, where outputs have settled
      @(negedge clk_sys_i);
      if (i < 32) begin
        ra[31-i] = sout_i[0];
        rb[31-i] = sout_i[1];
        rc[31-i] = sout_i[2];
      end else begin
        tail = sout_i;
      end
      @(posedge clk_sys_i);
    end
    sync_n_o <= 1'b1;
    din_o <= ~din_o;
    repeat (8) @(posedge clk_sys_i);
  endtask : frame
endmodule : host_model
`default_nettype wire

// ---- sim/adc_control_register_chain_bench.sv ----
// bench for the configuration register block and its serial link
`timescale 1ns/1ns
`default_nettype none
module adc_control_register_chain_bench;
  import cfg_pkg::*;
  logic clk_sys_i, rst_i, busy, irq, cclk, cs_n, wr_n, chain_en, sw, ser;
  logic sclk, sync_n, din, oe_n, stat;
  logic [15:0] db;
  logic [2:0] chn, sout, tail;
  logic [31:0] creg, ra, rb, rc;
  converter_configuration_t eff;
  conv_words_t words;
  int error_cnt = 0;
  int n_checks = 0;
  // interleaved start with ext clock, unused zero, auto sleep, no pair sleep
  localparam logic [31:0] W1 = 32'hF6F70C55;
  adc_control_register_chain adc_control_register_chain_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .pins_i({sclk, sync_n, din, cs_n, wr_n, chain_en, sw, ser,
      ser ? {db[15:6], chn, db[2:0]} : db}),
    .conv_words_i(words), .conv_busy_i(busy), .conv_irq_i(irq),
    .int_conv_clk_i(cclk), .eff_cfg_o(eff),
    .converter_configuration_o(creg), .serial_out_port_o(sout),
    .status_pin_o(stat), .shared_clk_o(), .shared_clk_oe_n_o(oe_n));
  host_model host_model_inst (.clk_sys_i(clk_sys_i), .sout_i(sout),
    .sclk_o(sclk), .sync_n_o(sync_n), .din_o(din), .chain_o(chn));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : wt
  task automatic fr(input logic [31:0] w, input int nb);
    host_model_inst.frame(w, nb, ra, rb, rc, tail);
    wt(4);
  endtask : fr
  task automatic pw(input logic [15:0] d);
    db <= d;
    wr_n <= 1'b0;
    wt(6);
    wr_n <= 1'b1;
    wt(6);
  endtask : pw
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cclk <= ~cclk;
  initial begin
    repeat (10000) @(posedge clk_sys_i);
    error_cnt++;
    close_out();
  end
  initial begin
    {rst_i, cs_n, wr_n, sw, ser, cclk} = 6'b111110;
    {chain_en, busy, irq, db} = '0;
    words = {32'hC0C00003, 32'hB0B00002, 32'hA0A00001};
    wt(2);
    rst_i <= 1'b0;
    wt(4);
    check(creg, 32'h000003FF);
    check(eff, 32'h000003FF);
    fr(W1, 32);
    check(creg, W1);
    check(eff, W1);
    check(oe_n, 1'b1);
    for (int i = 0; i < 2; i++) begin
      irq <= i[0];
      wt(3);
      check(stat, i[0]);
    end
    irq <= 1'b0;
    fr(32'h0, 32);
    check(ra, W1);
    check(rb, W1);
    check(rc, W1);
    check(creg, 32'h00F70C55);
    fr(32'h00010400, 32);
    check(ra, 32'h00F70C55);
    check(creg, 32'h00010400);
    check(oe_n, 1'b0);
    for (int i = 0; i < 2; i++) begin
      busy <= i[0];
      wt(3);
      check(stat, i[0]);
    end
    busy <= 1'b0;
    fr(32'h0, 32);
    check(ra, words.port_a);
    check(rb, words.port_b);
    check(rc, words.port_c);
    fr(32'hFF000000, 31);
    check(creg, 32'h00010400);
    chain_en <= 1'b1;
    fr(32'h0, 33);
    check(tail, 3'b011);
    chain_en <= 1'b0;
    fr(32'h0, 33);
    check(tail, 3'b000);
    sw <= 1'b0;
    wt(8);
    check(eff, 32'h00010000);
    check(oe_n, 1'b1);
    fr(W1, 32);
    check(creg, 32'h00010400);
    {sw, ser, cs_n} <= 3'b100;
    wt(8);
    pw(16'h81B2);
    check(creg, 32'h81010400);
    pw(16'h2C4D);
    check(creg, 32'h81B22C4D);
    close_out();
  end
endmodule : adc_control_register_chain_bench
`default_nettype wire
